// ===== core/pls_phy_led_status_driver.sv
// Function
// RQ1 - Scheme latched from strap and bit at reset
// RQ2 - Bit 1, strap high: individual scheme
// RQ3 - Bit 1, strap low: colour-code scheme
// RQ4 - Bit 0: enhanced scheme, strap ignored
// RQ5 - Individual: output b shows link
// RQ6 - Individual: output a blinks on activity
// RQ7 - Isolate darkens outputs in legacy schemes
// RQ8 - Power-down darkens outputs in all schemes
// RQ9 - Colour code: speed selects lit outputs
// RQ10 - Colour code: lit outputs toggle on activity
// RQ11 - Enhanced: each output has own function
// RQ12 - Code 0: link lit, activity toward dark
// RQ13 - Codes 1-6: code 0 on given speeds
// RQ14 - Code 8: full duplex lit, collisions blink
// RQ15 - Code 9: collision blinks toward lit
// RQ16 - Code 10: activity, optionally transmit only
// RQ17 - Code 12: lit on negotiation fault
// RQ18 - Code 14 dark, code 15 lit
// RQ19 - Blink rate or stretch length per output
// RQ20 - Dimming: 5 kHz, 20% duty when lit
// RQ21 - Reserved codes 7, 11, 13 dark
// RQ22 - Outputs active low
`timescale 1ns/1ps
`include "pls_defs.svh"

// ****************************************
// Event shaper: blink or pulse stretch
// ****************************************
module pls_event_shaper #(
	parameter int BASE_CYC = 5000000
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       evt,
	input  wire logic       stretchEn,
	input  wire logic [1:0] rate,
	output logic            shaped
);
	logic [31:0] cnt_q;
	logic [31:0] lenCyc;
	logic        phase_q;
	// Stretch length is twice the blink half period
	assign lenCyc = 32'(BASE_CYC >> rate) << stretchEn; // RQ19
	// Blink toggles each half period while events persist; stretch holds a period
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_q   <= 32'h0;
			phase_q <= 1'b0;
		end else if (cnt_q != 32'h0) begin
			cnt_q <= cnt_q - 32'h1;
		end else if (evt || phase_q) begin
			cnt_q   <= lenCyc - 32'h1; // RQ19
			phase_q <= stretchEn ? evt : ~phase_q; // RQ19
		end
	end
	assign shaped = phase_q | (stretchEn & evt);
endmodule

// ****************************************
// Top
// ****************************************
module pls_phy_led_status_driver #(
	parameter int BLINK_HALF_CYC = `PLS_CLK_HZ / `PLS_BLINK_MHZ_MIN * 1000 / 2,
	parameter int STRETCH_CYC    = `PLS_CLK_HZ / 1000 * `PLS_STRETCH_MS * 8,
	parameter int DIM_CYC        = `PLS_CLK_HZ / `PLS_DIM_HZ
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       modeStrap,
	input  wire logic       legacy_scheme_select_bit,
	input  wire logic       isolate_bit,
	input  wire logic       powerDown,
	input  wire logic       linkUp,
	input  wire logic [1:0] linkSpeed,
	input  wire logic       fullDuplex,
	input  wire logic       rxActivity,
	input  wire logic       txActivity,
	input  wire logic       collision,
	input  wire logic       anegFault,
	input  wire logic [3:0] fnSelA,
	input  wire logic [3:0] fnSelB,
	input  wire logic [1:0] stretchEnable,
	input  wire logic [3:0] rateSel,
	input  wire logic       txOnlySelect,
	input  wire logic       dimEnable,
	output logic            indicator_out_a,
	output logic            indicator_out_b
);
	if (BLINK_HALF_CYC < 8 || STRETCH_CYC != 2 * BLINK_HALF_CYC || DIM_CYC < 5) begin : gBadParam
		$error("pls: timing parameters out of range");
	end

	// ****************************************
	// Strap synchroniser and scheme latch
	// ****************************************
	logic [1:0] strapSync_q;
	logic       latchDone_q;
	pls_pkg::pls_scheme_e scheme_q;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) strapSync_q <= 2'b00;
		else     strapSync_q <= {strapSync_q[0], modeStrap};
	end
	logic [1:0] cfgWait_q;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cfgWait_q   <= 2'h0;
			latchDone_q <= 1'b0;
			scheme_q    <= pls_pkg::PLS_ENHANCED;
		end else if (!latchDone_q) begin
			cfgWait_q <= cfgWait_q + 2'h1;
			if (cfgWait_q == 2'h3) begin
				latchDone_q <= 1'b1; // RQ1
				if (!legacy_scheme_select_bit)
					scheme_q <= pls_pkg::PLS_ENHANCED; // RQ4
				else if (strapSync_q[1])
					scheme_q <= pls_pkg::PLS_INDIVIDUAL; // RQ2
				else
					scheme_q <= pls_pkg::PLS_COLOUR; // RQ3
			end
		end
	end

	// ****************************************
	// Input synchronisers
	// ****************************************
	localparam int NS = 10;
	logic [NS-1:0] raw;
	logic [NS-1:0] s1_q;
	logic [NS-1:0] s2_q;
	assign raw = {isolate_bit, powerDown, linkUp, linkSpeed, fullDuplex,
		rxActivity, txActivity, collision, anegFault};
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
		end
	end
	logic       iso, pdn, lnk, fdx, rxa, txa, act, col, anf;
	logic [1:0] spd;
	assign {iso, pdn, lnk, spd, fdx, rxa, txa, col, anf} = s2_q;
	assign act = rxa | txa;

	// ****************************************
	// Legacy blink
	// ****************************************
	logic legBlink;
	pls_event_shaper #(.BASE_CYC(BLINK_HALF_CYC)) uLegacy (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.evt      (act & lnk),
		.stretchEn(1'b0),
		.rate     (2'h0),
		.shaped   (legBlink)
	);

	// ****************************************
	// Enhanced per-output shapers
	// ****************************************
	logic [1:0] actShaped, colShaped;
	logic [1:0] actEvt;
	// Transmit-only activity applies to the activity code alone
	assign actEvt[0] = (fnSelA == `PLS_FN_ACTIVITY && txOnlySelect) ? txa : act; // RQ16
	assign actEvt[1] = (fnSelB == `PLS_FN_ACTIVITY && txOnlySelect) ? txa : act; // RQ16
	for (genvar g = 0; g < 2; g++) begin : gShape
		pls_event_shaper #(.BASE_CYC(BLINK_HALF_CYC)) uAct (
			.ref_clk  (ref_clk),
			.rst      (rst),
			.evt      (actEvt[g]),
			.stretchEn(stretchEnable[g]),
			.rate     (rateSel[2*g +: 2]),
			.shaped   (actShaped[g])
		);
		pls_event_shaper #(.BASE_CYC(BLINK_HALF_CYC)) uCol (
			.ref_clk  (ref_clk),
			.rst      (rst),
			.evt      (col),
			.stretchEn(stretchEnable[g]),
			.rate     (rateSel[2*g +: 2]),
			.shaped   (colShaped[g])
		);
	end

	// Lit when true; index 0 is output a
	function automatic logic fnLit(input logic [3:0] fn, input logic a, input logic c);
		logic sp;
		sp = 1'b0;
		case (fn)
			`PLS_FN_LINK_ANY:    sp = 1'b1;
			`PLS_FN_LINK_1000:   sp = (spd == `PLS_SPD_1000);
			`PLS_FN_LINK_100:    sp = (spd == `PLS_SPD_100);
			`PLS_FN_LINK_10:     sp = (spd == `PLS_SPD_10);
			`PLS_FN_LINK_100_1G: sp = (spd != `PLS_SPD_10);
			`PLS_FN_LINK_10_1G:  sp = (spd != `PLS_SPD_100);
			`PLS_FN_LINK_10_100: sp = (spd != `PLS_SPD_1000);
			default:             sp = 1'b0;
		endcase
		case (fn)
			`PLS_FN_LINK_ANY, `PLS_FN_LINK_1000, `PLS_FN_LINK_100, `PLS_FN_LINK_10,
			`PLS_FN_LINK_100_1G, `PLS_FN_LINK_10_1G, `PLS_FN_LINK_10_100:
				fnLit = lnk & sp & ~a; // RQ12 RQ13
			`PLS_FN_DUPLEX_COL: fnLit = lnk & (fdx | c); // RQ14
			`PLS_FN_COLLISION:  fnLit = c; // RQ15
			`PLS_FN_ACTIVITY:   fnLit = a; // RQ16
			`PLS_FN_ANEG_FAULT: fnLit = anf; // RQ17
			`PLS_FN_FORCE_OFF:  fnLit = 1'b0; // RQ18
			`PLS_FN_FORCE_ON:   fnLit = 1'b1; // RQ18
			default:            fnLit = 1'b0; // RQ21
		endcase
	endfunction

	// ****************************************
	// Scheme mux
	// ****************************************
	logic litA, litB;
	logic bothOn, onlyA, onlyB;
	always_comb begin
		litA   = 1'b0;
		litB   = 1'b0;
		onlyB  = lnk & (spd == `PLS_SPD_1000);
		onlyA  = lnk & (spd == `PLS_SPD_100);
		bothOn = lnk & (spd == `PLS_SPD_10);
		case (scheme_q)
			pls_pkg::PLS_INDIVIDUAL: begin
				litB = lnk; // RQ5
				litA = legBlink; // RQ6
				if (iso) begin
					litA = 1'b0; // RQ7
					litB = 1'b0;
				end
			end
			pls_pkg::PLS_COLOUR: begin
				litB = (onlyB | bothOn) & ~legBlink; // RQ9 RQ10
				litA = (onlyA | bothOn) & ~legBlink; // RQ9 RQ10
				if (iso) begin
					litA = 1'b0; // RQ7
					litB = 1'b0;
				end
			end
			pls_pkg::PLS_ENHANCED: begin
				litA = fnLit(fnSelA, actShaped[0], colShaped[0]); // RQ11
				litB = fnLit(fnSelB, actShaped[1], colShaped[1]); // RQ11
			end
			default: begin
				litA = 1'b0;
				litB = 1'b0;
			end
		endcase
		if (pdn || !latchDone_q) begin
			litA = 1'b0; // RQ8
			litB = 1'b0;
		end
	end

	// ****************************************
	// Dimming
	// ****************************************
	logic [31:0] dimCnt_q;
	logic        dimOn;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)                                   dimCnt_q <= 32'h0;
		else if (dimCnt_q == 32'(DIM_CYC - 1))     dimCnt_q <= 32'h0;
		else                                       dimCnt_q <= dimCnt_q + 32'h1;
	end
	assign dimOn = dimCnt_q < 32'(DIM_CYC * `PLS_DIM_PCT / 100); // RQ20

	// ****************************************
	// Output registers
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			indicator_out_a <= `PLS_DARK;
			indicator_out_b <= `PLS_DARK;
		end else begin
			indicator_out_a <= (litA & (~dimEnable | dimOn)) ? `PLS_LIT : `PLS_DARK; // RQ22 RQ20
			indicator_out_b <= (litB & (~dimEnable | dimOn)) ? `PLS_LIT : `PLS_DARK; // RQ22 RQ20
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_pdnDark;
		@(posedge ref_clk) disable iff (rst)
		pdn |=> indicator_out_a && indicator_out_b;
	endproperty
	a_pdnDark: assert property (p_pdnDark) else $error("power-down not dark"); // RQ8

	property p_schemeHeld;
		@(posedge ref_clk) disable iff (rst)
		latchDone_q |=> $stable(scheme_q);
	endproperty
	a_schemeHeld: assert property (p_schemeHeld) else $error("scheme changed"); // RQ1

	property p_forceOn;
		@(posedge ref_clk) disable iff (rst)
		scheme_q == pls_pkg::PLS_ENHANCED && latchDone_q && !pdn && !dimEnable
			&& fnSelA == `PLS_FN_FORCE_ON |=> !indicator_out_a;
	endproperty
	a_forceOn: assert property (p_forceOn) else $error("force on failed"); // RQ18

	property p_reservedDark;
		@(posedge ref_clk) disable iff (rst)
		scheme_q == pls_pkg::PLS_ENHANCED && fnSelB == 4'h7 |=> indicator_out_b;
	endproperty
	a_reservedDark: assert property (p_reservedDark) else $error("reserved lit"); // RQ21

	property p_indivLink;
		@(posedge ref_clk) disable iff (rst)
		scheme_q == pls_pkg::PLS_INDIVIDUAL && latchDone_q && !pdn && !iso
			&& !dimEnable |=> indicator_out_b == !$past(lnk);
	endproperty
	a_indivLink: assert property (p_indivLink) else $error("link output wrong"); // RQ5

	property p_isoDark;
		@(posedge ref_clk) disable iff (rst)
		scheme_q != pls_pkg::PLS_ENHANCED && latchDone_q && iso
			|=> indicator_out_a && indicator_out_b;
	endproperty
	a_isoDark: assert property (p_isoDark) else $error("isolate not dark"); // RQ7
endmodule

// ===== core/pls_defs.svh
`ifndef PLS_DEFS_SVH
`define PLS_DEFS_SVH

// ****************************************
// Function codes
// ****************************************
`define PLS_FN_LINK_ANY    4'h0
`define PLS_FN_LINK_1000   4'h1
`define PLS_FN_LINK_100    4'h2
`define PLS_FN_LINK_10     4'h3
`define PLS_FN_LINK_100_1G 4'h4
`define PLS_FN_LINK_10_1G  4'h5
`define PLS_FN_LINK_10_100 4'h6
`define PLS_FN_DUPLEX_COL  4'h8
`define PLS_FN_COLLISION   4'h9
`define PLS_FN_ACTIVITY    4'ha
`define PLS_FN_ANEG_FAULT  4'hc
`define PLS_FN_FORCE_OFF   4'he
`define PLS_FN_FORCE_ON    4'hf

// ****************************************
// Speed codes
// ****************************************
`define PLS_SPD_10   2'h0
`define PLS_SPD_100  2'h1
`define PLS_SPD_1000 2'h2

// ****************************************
// Timing
// ****************************************
`define PLS_CLK_HZ        25000000
`define PLS_BLINK_MHZ_MIN 2500
`define PLS_STRETCH_MS    50
`define PLS_DIM_HZ        5000
`define PLS_DIM_PCT       20
`define PLS_LIT           1'b0
`define PLS_DARK          1'b1

`endif

// ===== core/pls_pkg.sv
package pls_pkg;
	typedef enum logic [1:0] {
		PLS_INDIVIDUAL = 2'b00,
		PLS_COLOUR     = 2'b01,
		PLS_ENHANCED   = 2'b10
	} pls_scheme_e;
endpackage

// ===== tb/pls_led_model.sv
`timescale 1ns/1ps
// ****************************************
// Indicator lamps behind series resistors
// ****************************************
module pls_led_model (
	input  wire logic ledA,
	input  wire logic ledB,
	output logic      litA,
	output logic      litB
);
	// Lamp conducts only while its pin pulls low
	assign litA = (ledA === 1'b0);
	assign litB = (ledB === 1'b0);
endmodule

// ===== tb/pls_phy_led_status_driver_test.sv
`timescale 1ns/1ps
// ****************************************
// Status indicator bench
// ****************************************
module pls_phy_led_status_driver_test;
	localparam int HALF = 64;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        modeStrap, legacy_scheme_select_bit, isolate_bit, powerDown, linkUp;
	logic        fullDuplex, rxActivity, txActivity, collision, anegFault, txOnlySelect;
	logic        dimEnable, indicator_out_a, indicator_out_b, litA, litB;
	logic [1:0]  linkSpeed, stretchEnable;
	logic [3:0]  fnSelA, fnSelB, rateSel;
	int          errCount = 0;
	int          nChecks = 0;
	int          tA, lA, lB, same;
	// Code, link, speed, duplex, fault, expected pin level
	logic [23:0] rows [26] = '{24'h010000, 24'h000001, 24'h112000, 24'h111001, 24'h211000,
		24'h210001, 24'h310000, 24'h312001, 24'h411000, 24'h410001, 24'h512000, 24'h511001,
		24'h610000, 24'h612001, 24'h812100, 24'h812001, 24'h802101, 24'h912001, 24'ha12001,
		24'hc00010, 24'hc12001, 24'he12111, 24'hf00000, 24'h712111, 24'hb12111, 24'hd12111};

	always #20 ref_clk = ~ref_clk;

	pls_phy_led_status_driver #(.BLINK_HALF_CYC(HALF), .STRETCH_CYC(2 * HALF), .DIM_CYC(10)) DUT (
		.ref_clk, .rst, .modeStrap, .legacy_scheme_select_bit, .isolate_bit, .powerDown,
		.linkUp, .linkSpeed, .fullDuplex, .rxActivity, .txActivity, .collision, .anegFault,
		.fnSelA, .fnSelB, .stretchEnable, .rateSel, .txOnlySelect, .dimEnable,
		.indicator_out_a, .indicator_out_b);

	pls_led_model lamps (.ledA(indicator_out_a), .ledB(indicator_out_b), .litA, .litB);

	task automatic chk(input string what, input logic exp, input logic got);
		nChecks++;
		if (got !== exp) begin
			errCount++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic chkRange(input string what, input int lo, input int hi, input int got);
		nChecks++;
		if (got < lo || got > hi) begin
			errCount++;
			$display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic stat(input logic [7:0] v);
		@(posedge ref_clk);
		{linkUp, linkSpeed, fullDuplex, rxActivity, txActivity, collision, anegFault} <= v;
		settle(6);
	endtask

	task automatic doReset(input logic strap, input logic leg);
		@(posedge ref_clk);
		rst <= 1'b1;
		{linkUp, linkSpeed, fullDuplex, rxActivity, txActivity, collision, anegFault} <= 8'h00;
		modeStrap <= strap;
		legacy_scheme_select_bit <= leg;
		settle(2);
		chk("pin a in reset", 1'b1, indicator_out_a);
		rst <= 1'b0;
		settle(5);
	endtask

	// Counts toggles of a, lit cycles of a and b, cycles with equal pins
	task automatic watch(input int n);
		logic prev;
		prev = indicator_out_a;
		tA = 0;
		lA = 0;
		lB = 0;
		same = 0;
		repeat (n) begin
			@(negedge ref_clk);
			tA += (indicator_out_a !== prev);
			prev = indicator_out_a;
			lA += litA;
			lB += litB;
			same += (indicator_out_a === indicator_out_b);
		end
		@(posedge ref_clk);
	endtask

	task automatic testDone();
		$display("Checks %0d errors %0d", nChecks, errCount);
		if (errCount == 0 && nChecks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		settle(10000);
		errCount++;
		testDone();
	end

	initial begin
		{modeStrap, legacy_scheme_select_bit, isolate_bit, powerDown, fullDuplex} = '0;
		{rxActivity, txActivity, collision, anegFault, txOnlySelect, dimEnable} = '0;
		{linkUp, linkSpeed, stretchEnable, fnSelA, fnSelB} = '0;
		rateSel = 4'hf;
		doReset(1'b1, 1'b0);
		foreach (rows[i]) begin
			@(posedge ref_clk);
			fnSelA <= rows[i][23:20];
			fnSelB <= 4'hf;
			stat({rows[i][16], rows[i][13:12], rows[i][8], 3'h0, rows[i][4]});
			chk("table pin a", rows[i][0], indicator_out_a);
			chk("table pin b", 1'b1, litB);
		end
		fnSelA <= 4'hf;
		fnSelB <= 4'h7;
		isolate_bit <= 1'b1;
		stat(8'h00);
		chk("isolate enhanced", 1'b1, litA);
		chk("reserved b", 1'b0, litB);
		powerDown <= 1'b1;
		settle(6);
		chk("power-down a", 1'b0, litA);
		chk("power-down b", 1'b0, litB);
		isolate_bit <= 1'b0;
		powerDown <= 1'b0;
		legacy_scheme_select_bit <= 1'b1;
		modeStrap <= 1'b0;
		settle(8);
		chk("scheme held", 1'b1, litA);
		fnSelA <= 4'h0;
		fnSelB <= 4'ha;
		txOnlySelect <= 1'b1;
		stat(8'hc8);
		watch(128);
		chkRange("code 0 toggles", 12, 20, tA);
		chkRange("code 10 rx only", 0, 0, lB);
		fnSelA <= 4'h8;
		stat(8'hc6);
		watch(128);
		chkRange("code 8 toggles", 12, 20, tA);
		chkRange("code 10 tx lit", 56, 72, lB);
		fnSelA <= 4'h9;
		stretchEnable <= 2'h1;
		settle(20);
		watch(128);
		chkRange("code 9 stretched", 128, 128, lA);
		fnSelA <= 4'hf;
		stretchEnable <= 2'h0;
		dimEnable <= 1'b1;
		settle(20);
		watch(100);
		chkRange("dimmed lit cycles", 20, 20, lA);
		dimEnable <= 1'b0;
		doReset(1'b1, 1'b1);
		stat(8'h00);
		chk("no link b", 1'b0, litB);
		chk("idle a", 1'b0, litA);
		stat(8'h88);
		watch(256);
		chkRange("individual link", 256, 256, lB);
		chkRange("individual blink", 3, 5, tA);
		isolate_bit <= 1'b1;
		settle(6);
		chk("isolate a", 1'b0, litA);
		chk("isolate b", 1'b0, litB);
		isolate_bit <= 1'b0;
		doReset(1'b0, 1'b1);
		for (int s = 0; s < 4; s++) begin
			stat({s < 3, 2'(s), 5'h00});
			chk("colour a", s == 0 || s == 1, litA);
			chk("colour b", s == 0 || s == 2, litB);
		end
		stat(8'h84);
		watch(256);
		chkRange("colour toggles", 3, 5, tA);
		chkRange("colour together", 256, 256, same);
		isolate_bit <= 1'b1;
		settle(6);
		chk("colour isolate", 1'b0, litA | litB);
		testDone();
	end
endmodule
